// *** shared/ppoc_pkg.sv ***
// Shared constants and carriers for the port power and overcurrent controller
package ppoc_pkg;

   // Clock and tick timing
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned N_PORTS_DEF    = 7;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_LOCKOUT    = 16'h30E1;
   localparam logic [15:0] IDX_MIN_PULSE  = 16'h30EA;
   localparam logic [15:0] IDX_WINDOW     = 16'h30EB;
   localparam logic [15:0] IDX_CONFIG     = 16'h30F0;
   localparam logic [15:0] IDX_POWER      = 16'h30F1;
   localparam logic [15:0] IDX_OC_FLAG    = 16'h30F2;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h30F3;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h30F4;

   // Reset values and field layout
   localparam logic [7:0]  RST_LOCKOUT    = 8'h0A;
   localparam logic [3:0]  RST_MIN_PULSE  = 4'h5;
   localparam logic [7:0]  RST_WINDOW     = 8'h14;
   localparam int unsigned MIN_PULSE_W    = 4;
   localparam int unsigned GANG_BIT       = 0;

   typedef struct packed {
      logic [7:0]             lockout;
      logic [MIN_PULSE_W-1:0] min_pulse;
      logic [7:0]             window;
   } ppoc_cfg_s;

   typedef struct packed {
      logic                   pwr_q;
      logic [7:0]             lock_cnt;
      logic [3:0]             low_cnt;
      logic [7:0]             win_cnt;
      logic                   win_open;
      logic                   low_q;
      logic                   tripped;
      logic                   det;
   } ppoc_det_s;

endpackage

// *** logic/ppoc_ctrl.sv ***
// Port power switching and overcurrent detection with APB register access
`timescale 1ns/1ns

// Overcurrent filter for one sense line, clocked by pclk with timers stepped by the 1 ms tick
module ppoc_port_det
   import ppoc_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire logic      ce,
   input  wire logic      tick,
   input  wire logic      powered,
   input  wire logic      pin_low,
   input  wire ppoc_cfg_s cfg,
   output logic           det_o
);

   ppoc_det_s r;
   ppoc_det_s n;
   logic      armed;
   logic      group_start;
   logic      single_hit;
   logic      double_hit;

   assign armed       = powered && r.pwr_q && (r.lock_cnt == 8'h00) && !r.tripped;
   assign group_start = pin_low && !r.low_q;
   // R10 single long pulse
   assign single_hit  = pin_low && (r.low_cnt >= cfg.min_pulse);
   // R11 second low group
   assign double_hit  = group_start && r.win_open;

   always_comb begin
      n       = r;
      n.det   = 1'b0;
      n.pwr_q = powered;
      n.low_q = pin_low;
      if (!powered) begin
         n.lock_cnt = 8'h00;
         n.low_cnt  = 4'h0;
         n.win_cnt  = 8'h00;
         n.win_open = 1'b0;
         n.tripped  = 1'b0;
         n.low_q    = 1'b0;
      end else if (!r.pwr_q) begin
         // R12 lockout starts
         n.lock_cnt = cfg.lockout;
         n.low_q    = 1'b0;
      end else if (r.lock_cnt != 8'h00) begin
         // R12 pin ignored
         n.low_q = 1'b0;
         if (tick) begin
            n.lock_cnt = r.lock_cnt - 8'h01;
         end
      end else if (!r.tripped) begin
         // R9 continuous sampling
         if (!pin_low) begin
            n.low_cnt = 4'h0;
         end else if (tick && (r.low_cnt != 4'hF)) begin
            n.low_cnt = r.low_cnt + 4'h1;
         end
         // R11 window timing
         if (r.win_open && tick) begin
            if (r.win_cnt <= 8'h01) begin
               n.win_open = 1'b0;
               n.win_cnt  = 8'h00;
            end else begin
               n.win_cnt = r.win_cnt - 8'h01;
            end
         end
         if (group_start && !r.win_open) begin
            n.win_open = 1'b1;
            n.win_cnt  = cfg.window;
         end
         if (single_hit || double_hit) begin
            // Latch off until the next power cycle so one fault reports once
            n.det      = 1'b1;
            n.tripped  = 1'b1;
            n.win_open = 1'b0;
            n.low_cnt  = 4'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign det_o = r.det;

   AST_DET_NEEDS_POWER: assert property (  // R9
      @(posedge pclk) disable iff (!presetn)
      $rose(r.det) |-> $past(powered) && $past(ce))
      else $error("overcurrent reported on an unpowered line");

   AST_LOCK_LOAD: assert property (  // R12
      @(posedge pclk) disable iff (!presetn)
      ce && powered && !r.pwr_q |=> r.lock_cnt == $past(cfg.lockout) && !r.det)
      else $error("lockout not loaded at power on");

   AST_LOCKED_SILENT: assert property (  // R12
      @(posedge pclk) disable iff (!presetn)
      (r.lock_cnt != 8'h00) |=> !r.det)
      else $error("detection during lockout");

   AST_SINGLE_PULSE: assert property (  // R10
      @(posedge pclk) disable iff (!presetn)
      ce && armed && pin_low && (r.low_cnt >= cfg.min_pulse) |=> r.det)
      else $error("long low pulse not detected");

   AST_DOUBLE_PULSE: assert property (  // R11
      @(posedge pclk) disable iff (!presetn)
      ce && armed && pin_low && !r.low_q && r.win_open |=> r.det)
      else $error("second low group in window not detected");

   COV_SINGLE: cover property (@(posedge pclk) disable iff (!presetn)
      ce && armed && single_hit && !double_hit);
   COV_DOUBLE: cover property (@(posedge pclk) disable iff (!presetn)
      ce && armed && double_hit && !single_hit);

endmodule // ppoc_port_det

// Contract
// R1 - Each downstream port has one shared pin for power command and overcurrent sense.
// R2 - Ganged mode uses one common pin for power and sense of all ports.
// R3 - In ganged mode a common-pin overcurrent flags every port at once.
// R4 - Ganged mode can be set only during the configuration load stage.
// R5 - After reset the block runs in individual per-port mode.
// R6 - Power off drives the pin low and disables the pull-up.
// R7 - Power on releases the driver and enables the pull-up, open-drain style.
// R8 - The external switch pulls the line low on overcurrent; low means fault.
// R9 - A powered port's pin is sampled continuously for overcurrent.
// R10 - Low lasting at least the minimum pulse width declares overcurrent.
// R11 - Two low groups inside the window opened by the first declare overcurrent.
// R12 - After power on the pin is ignored until the lockout time ends.
// R13 - Minimum pulse field bits 3:0, 1 ms steps, default 5; bits 7:4 read zero.
// R14 - Eight-bit double-pulse window in 1 ms steps, reset 14h.
// R15 - Eight-bit lockout time in 1 ms steps, reset 0Ah.
// R16 - Software never programs the window or lockout registers to zero.
// R17 - A 1 ms tick from the core clock drives per-port timers.
// R18 - An overcurrent sets a per-port flag held until read or power off.
module ppoc_ctrl
   import ppoc_pkg::*;
#(
   parameter int unsigned N_PORTS     = N_PORTS_DEF,
   parameter int unsigned TICK_CYCLES = ppoc_pkg::TICK_CYCLES
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               pce,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [17:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire logic               cfg_stage,
   input  wire logic [N_PORTS-1:0] port_power_sense_pin_i,
   output logic [N_PORTS-1:0]      port_power_sense_pin_o,
   output logic [N_PORTS-1:0]      port_power_sense_pin_oe,
   output logic [N_PORTS-1:0]      port_pull_up_en,
   input  wire logic               common_power_sense_pin_i,
   output logic                    common_power_sense_pin_o,
   output logic                    common_power_sense_pin_oe,
   output logic                    common_pull_up_en,
   output logic                    irq
);

   localparam int unsigned TW = $clog2(TICK_CYCLES);

   if (N_PORTS < 1 || N_PORTS > 31 || TICK_CYCLES < 2) begin : g_bad_params
      $error("ppoc_ctrl: unsupported N_PORTS or TICK_CYCLES");
   end

   typedef struct packed {
      ppoc_cfg_s          cfg;
      logic               gang;
      logic [N_PORTS-1:0] power;
      logic [N_PORTS-1:0] oc_flag;
      logic [N_PORTS-1:0] irq_stat;
      logic [N_PORTS-1:0] irq_mask;
      logic [TW-1:0]      tick_cnt;
      logic               tick;
      logic [N_PORTS-1:0] sync1;
      logic [N_PORTS-1:0] sync2;
      logic [N_PORTS-1:0] sync3;
      logic [N_PORTS-1:0] filt;
      logic [2:0]         com_sync;
      logic               com_filt;
      logic [N_PORTS-1:0] pin_o;
      logic [N_PORTS-1:0] pin_oe;
      logic [N_PORTS-1:0] pin_pu;
      logic               com_o;
      logic               com_oe;
      logic               com_pu;
      logic               irq;
      logic               pready;
      logic [31:0]        prdata;
      logic               pslverr;
   } ppoc_state_s;

   ppoc_state_s        r;
   ppoc_state_s        n;
   logic [N_PORTS-1:0] port_det;
   logic               com_det;
   logic               sel_lockout;
   logic               sel_min;
   logic               sel_window;
   logic               sel_config;
   logic               sel_power;
   logic               sel_flag;
   logic               sel_stat;
   logic               sel_mask;
   logic               sel_any;
   logic               setup_ph;
   logic               access_ph;
   logic               acc_wr;
   logic               acc_rd;
   logic [N_PORTS-1:0] events;
   logic [N_PORTS-1:0] flag_clr;

   // Word-aligned decode of the register index
   always_comb begin
      sel_lockout = 1'b0;
      sel_min     = 1'b0;
      sel_window  = 1'b0;
      sel_config  = 1'b0;
      sel_power   = 1'b0;
      sel_flag    = 1'b0;
      sel_stat    = 1'b0;
      sel_mask    = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         sel_lockout = 1'b0;
      end else if (paddr[17:2] == IDX_LOCKOUT) begin
         sel_lockout = 1'b1;
      end else if (paddr[17:2] == IDX_MIN_PULSE) begin
         sel_min = 1'b1;
      end else if (paddr[17:2] == IDX_WINDOW) begin
         sel_window = 1'b1;
      end else if (paddr[17:2] == IDX_CONFIG) begin
         sel_config = 1'b1;
      end else if (paddr[17:2] == IDX_POWER) begin
         sel_power = 1'b1;
      end else if (paddr[17:2] == IDX_OC_FLAG) begin
         sel_flag = 1'b1;
      end else if (paddr[17:2] == IDX_IRQ_STATUS) begin
         sel_stat = 1'b1;
      end else if (paddr[17:2] == IDX_IRQ_MASK) begin
         sel_mask = 1'b1;
      end
   end

   assign sel_any   = sel_lockout | sel_min | sel_window | sel_config |
                      sel_power | sel_flag | sel_stat | sel_mask;
   assign setup_ph  = psel && !penable && !r.pready;
   assign access_ph = psel && penable && r.pready;
   assign acc_wr    = access_ph && pwrite && sel_any;
   assign acc_rd    = access_ph && !pwrite && sel_any;

   // R3 common fault flags all ports
   assign events    = port_det | {N_PORTS{com_det}};

   always_comb begin
      n      = r;
      n.tick = 1'b0;
      // R17 millisecond tick
      if (r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
         n.tick_cnt = '0;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = r.tick_cnt + 1'b1;
      end

      // Pin samples settle only when the last two stages agree
      n.sync1 = port_power_sense_pin_i;
      n.sync2 = r.sync1;
      n.sync3 = r.sync2;
      for (int i = 0; i < N_PORTS; i++) begin
         if (r.sync2[i] == r.sync3[i]) begin
            n.filt[i] = r.sync3[i];
         end
      end
      n.com_sync = {r.com_sync[1:0], common_power_sense_pin_i};
      if (r.com_sync[1] == r.com_sync[2]) begin
         n.com_filt = r.com_sync[2];
      end

      // APB: read data is prepared in setup, writes land in access
      n.pready = setup_ph;
      if (setup_ph) begin
         n.pslverr = !sel_any;
         n.prdata  = 32'h0000_0000;
         if (sel_lockout) begin
            n.prdata = 32'(r.cfg.lockout);
         end else if (sel_min) begin
            // R13 upper bits read zero
            n.prdata = 32'(r.cfg.min_pulse);
         end else if (sel_window) begin
            n.prdata = 32'(r.cfg.window);
         end else if (sel_config) begin
            n.prdata = 32'(r.gang);
         end else if (sel_power) begin
            n.prdata = 32'(r.power);
         end else if (sel_flag) begin
            n.prdata = 32'(r.oc_flag);
         end else if (sel_stat) begin
            n.prdata = 32'(r.irq_stat);
         end else if (sel_mask) begin
            n.prdata = 32'(r.irq_mask);
         end
      end

      if (acc_wr) begin
         if (sel_lockout) begin
            // R15 lockout in ms
            n.cfg.lockout = pwdata[7:0];
         end else if (sel_min) begin
            // R13 pulse width code
            n.cfg.min_pulse = pwdata[MIN_PULSE_W-1:0];
         end else if (sel_window) begin
            // R14 window in ms
            n.cfg.window = pwdata[7:0];
         end else if (sel_config) begin
            // R4 gang only while loading
            if (cfg_stage) begin
               n.gang = pwdata[GANG_BIT];
            end
         end else if (sel_power) begin
            n.power = pwdata[N_PORTS-1:0];
         end else if (sel_mask) begin
            n.irq_mask = pwdata[N_PORTS-1:0];
         end
      end

      // R18 sticky fault flag
      flag_clr = r.power & ~n.power;
      if (acc_rd && sel_flag) begin
         flag_clr = '1;
      end
      n.oc_flag  = (r.oc_flag & ~flag_clr) | events;
      if (acc_wr && sel_stat) begin
         n.irq_stat = (r.irq_stat & ~pwdata[N_PORTS-1:0]) | events;
      end else begin
         n.irq_stat = r.irq_stat | events;
      end
      n.irq = |(r.irq_stat & r.irq_mask);

      // R1 per-port pin drive
      // R6 off drives low
      // R7 on releases with pull-up
      n.pin_o  = '0;
      n.pin_oe = r.gang ? '1 : ~r.power;
      n.pin_pu = r.gang ? '0 : r.power;
      // R2 common pin in gang mode
      n.com_o  = 1'b0;
      n.com_pu = r.gang && (|r.power);
      n.com_oe = !(r.gang && (|r.power));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r               <= '0;
         r.cfg.lockout   <= RST_LOCKOUT;
         r.cfg.min_pulse <= RST_MIN_PULSE;
         r.cfg.window    <= RST_WINDOW;
         // R5 individual mode
         r.gang          <= 1'b0;
         r.sync1         <= '1;
         r.sync2         <= '1;
         r.sync3         <= '1;
         r.filt          <= '1;
         r.com_sync      <= 3'h7;
         r.com_filt      <= 1'b1;
         r.pin_oe        <= '1;
         r.com_oe        <= 1'b1;
      end else if (pce) begin
         r <= n;
      end
   end

   // R8 low on the line means fault
   // R17 one filter per port
   for (genvar i = 0; i < N_PORTS; i++) begin : g_port
      ppoc_port_det u_det (
         .pclk    (pclk),
         .presetn (presetn),
         .ce      (pce),
         .tick    (r.tick),
         .powered (r.pin_pu[i]),
         .pin_low (!r.filt[i]),
         .cfg     (r.cfg),
         .det_o   (port_det[i])
      );
   end

   ppoc_port_det u_com_det (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (pce),
      .tick    (r.tick),
      .powered (r.com_pu),
      .pin_low (!r.com_filt),
      .cfg     (r.cfg),
      .det_o   (com_det)
   );

   assign pready                    = r.pready;
   assign prdata                    = r.prdata;
   assign pslverr                   = r.pslverr;
   assign port_power_sense_pin_o    = r.pin_o;
   assign port_power_sense_pin_oe   = r.pin_oe;
   assign port_pull_up_en           = r.pin_pu;
   assign common_power_sense_pin_o  = r.com_o;
   assign common_power_sense_pin_oe = r.com_oe;
   assign common_pull_up_en         = r.com_pu;
   assign irq                       = r.irq;

   AST_OFF_DRIVES_LOW: assert property (  // R6
      @(posedge pclk) disable iff (!presetn)
      pce && !r.gang && !r.power[0] |=> port_power_sense_pin_oe[0] && !port_pull_up_en[0]
                                        && !port_power_sense_pin_o[0])
      else $error("unpowered port not driven low");

   AST_ON_RELEASES: assert property (  // R7
      @(posedge pclk) disable iff (!presetn)
      pce && !r.gang && r.power[0] |=> !port_power_sense_pin_oe[0] && port_pull_up_en[0])
      else $error("powered port not released with pull-up");

   AST_GANG_FLAGS_ALL: assert property (  // R3
      @(posedge pclk) disable iff (!presetn)
      pce && com_det |=> &r.oc_flag)
      else $error("common fault did not flag every port");

   AST_GANG_LOCKED: assert property (  // R4
      @(posedge pclk) disable iff (!presetn)
      pce && acc_wr && sel_config && !cfg_stage |=> r.gang == $past(r.gang))
      else $error("gang mode changed outside configuration stage");

   AST_FLAG_HOLDS: assert property (  // R18
      @(posedge pclk) disable iff (!presetn)
      r.oc_flag[0] && !(acc_rd && sel_flag) && !(acc_wr && sel_power && !pwdata[0])
      |=> r.oc_flag[0])
      else $error("fault flag dropped without read or power off");

   AST_TICK_PERIOD: assert property (  // R17
      @(posedge pclk) disable iff (!presetn)
      pce && r.tick |-> r.tick_cnt == '0)
      else $error("tick not aligned to counter wrap");

   COV_GANG_FAULT: cover property (@(posedge pclk) disable iff (!presetn) r.gang && com_det);
   COV_FLAG_READ: cover property (@(posedge pclk) disable iff (!presetn)
      acc_rd && sel_flag && (|r.oc_flag));
   COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule // ppoc_ctrl

// *** dv/ppoc_switch_model.sv ***
// External power switches with open-drain fault flags on the sense lines
`timescale 1ns/1ns

module ppoc_switch_model #(
   parameter int unsigned N = 2
)(
   input  wire logic         pclk,
   input  wire logic [N-1:0] pin_o,
   input  wire logic [N-1:0] pin_oe,
   input  wire logic [N-1:0] pull_up,
   input  wire logic [N-1:0] fault,
   output logic [N-1:0]      pin_i,
   input  wire logic         com_o,
   input  wire logic         com_oe,
   input  wire logic         com_pu,
   input  wire logic         com_fault,
   output logic              com_i
);
   logic flip = 1'b0;

   // Undriven, unpulled line shows no stable level
   always @(posedge pclk) flip <= ~flip;

   function automatic logic lvl(logic o, logic oe, logic pu, logic f, logic fl);
      if (oe)
         return o;
      if (f)
         return 1'b0;
      if (pu)
         return 1'b1;
      return fl;
   endfunction

   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_i[i] = lvl(pin_o[i], pin_oe[i], pull_up[i], fault[i], flip);
      end
      com_i = lvl(com_o, com_oe, com_pu, com_fault, flip);
   end
endmodule // ppoc_switch_model

// *** dv/ppoc_ctrl_tb_top.sv ***
// Self-checking bench for the port power and overcurrent controller
`timescale 1ns/1ns

module ppoc_ctrl_tb_top;
   import ppoc_pkg::*;
   localparam int unsigned NP = 2;
   localparam int unsigned TC = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, cfg_stage = 1'b0, irq, err;
   logic [NP-1:0] pin_i, pin_o, pin_oe, pull_up, fault = '0;
   logic com_i, com_o, com_oe, com_pu, com_fault = 1'b0;
   int failures = 0, check_count = 0, cycles = 0;

   always #2 pclk = ~pclk;

   ppoc_ctrl #(.N_PORTS(NP), .TICK_CYCLES(TC)) i_ppoc_ctrl (
      .pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .cfg_stage(cfg_stage), .port_power_sense_pin_i(pin_i),
      .port_power_sense_pin_o(pin_o), .port_power_sense_pin_oe(pin_oe),
      .port_pull_up_en(pull_up), .common_power_sense_pin_i(com_i),
      .common_power_sense_pin_o(com_o), .common_power_sense_pin_oe(com_oe),
      .common_pull_up_en(com_pu), .irq(irq));

   ppoc_switch_model #(.N(NP)) i_ppoc_switch_model (
      .pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_up(pull_up), .fault(fault),
      .pin_i(pin_i), .com_o(com_o), .com_oe(com_oe), .com_pu(com_pu),
      .com_fault(com_fault), .com_i(com_i));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs about 1100 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic t_reset();
      chk({26'h0, pin_oe, pull_up, com_oe, com_pu}, {26'h0, 2'b11, 2'b00, 2'b10}, "reset pins");
      chk({29'h0, com_o, pin_o}, 32'h0, "pins drive zero");
      rdc(IDX_LOCKOUT, 32'h0000000A, "lockout reset");
      rdc(IDX_MIN_PULSE, 32'h00000005, "min pulse reset");
      rdc(IDX_WINDOW, 32'h00000014, "window reset");
      apb(1'b0, 16'h3000, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, IDX_MIN_PULSE, 32'hFFFFFFFF);
      rdc(IDX_MIN_PULSE, 32'h0000000F, "reserved bits");
      apb(1'b1, IDX_MIN_PULSE, 32'h00000002);
      apb(1'b1, IDX_WINDOW, 32'h000000FE);
      rdc(IDX_WINDOW, 32'h000000FE, "window rw");
      apb(1'b1, IDX_WINDOW, 32'h00000014);
      apb(1'b1, IDX_IRQ_MASK, 32'h00000003);
      $display("test reset done");
   endtask

   task automatic t_single();
      apb(1'b1, IDX_POWER, 32'h00000001);
      cyc(2);
      chk({pin_oe[0], pull_up[0]}, 32'h1, "power on pin");
      cyc(100);
      fault[0] <= 1'b1;
      cyc(80);
      fault[0] <= 1'b0;
      cyc(100);
      chk({31'h0, irq}, 32'h0, "lockout irq");
      rdc(IDX_OC_FLAG, 32'h0, "lockout flag");
      fault[0] <= 1'b1;
      cyc(60);
      fault[0] <= 1'b0;
      cyc(10);
      chk({31'h0, irq}, 32'h1, "single irq");
      rdc(IDX_OC_FLAG, 32'h1, "single flag");
      rdc(IDX_OC_FLAG, 32'h0, "flag cleared");
      apb(1'b1, IDX_IRQ_STATUS, 32'h1);
      rdc(IDX_IRQ_STATUS, 32'h0, "status w1c");
      cyc(2);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test single done");
   endtask

   task automatic t_double();
      apb(1'b1, IDX_POWER, 32'h00000003);
      cyc(260);
      fault[1] <= 1'b1;
      cyc(8);
      fault[1] <= 1'b0;
      cyc(30);
      chk({31'h0, irq}, 32'h0, "one group only");
      fault[1] <= 1'b1;
      cyc(8);
      fault[1] <= 1'b0;
      cyc(12);
      chk({31'h0, irq}, 32'h1, "double irq");
      rdc(IDX_OC_FLAG, 32'h2, "double flag");
      apb(1'b1, IDX_IRQ_STATUS, 32'h3);
      apb(1'b1, IDX_POWER, 32'h00000002);
      cyc(2);
      chk({pin_oe[0], pull_up[0]}, 32'h2, "power off pin");
      $display("test double done");
   endtask

   task automatic t_gang();
      apb(1'b1, IDX_CONFIG, 32'h1);
      rdc(IDX_CONFIG, 32'h0, "gang refused");
      cfg_stage <= 1'b1;
      apb(1'b1, IDX_CONFIG, 32'h1);
      cfg_stage <= 1'b0;
      rdc(IDX_CONFIG, 32'h1, "gang set");
      cyc(2);
      chk({26'h0, pin_oe, pull_up, com_oe, com_pu}, {26'h0, 2'b11, 2'b00, 2'b01}, "gang pins");
      cyc(260);
      com_fault <= 1'b1;
      cyc(60);
      com_fault <= 1'b0;
      cyc(10);
      rdc(IDX_OC_FLAG, 32'h3, "gang flags");
      rdc(IDX_IRQ_STATUS, 32'h3, "gang status");
      $display("test gang done");
   endtask

   initial begin
      cyc(8);
      presetn <= 1'b1;
      t_reset();
      t_single();
      t_double();
      t_gang();
      stop_test();
   end
endmodule // ppoc_ctrl_tb_top
